// ==== design/flash_spi_pkg.sv ====
// Shared types and constants of the serial flash front end.
// Assumes a 250 MHz core clock and a host-made serial clock.
package flash_spi_pkg;
  localparam int unsigned CORE_CLK_MHZ = 250;
  localparam int unsigned SCK_MAX_MHZ = 104;
  localparam int unsigned BYTE_BITS = 8;
  localparam int unsigned CNT_W = 3;
  localparam logic [CNT_W-1:0] CNT_LAST = 3'h7;
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
  localparam logic [CNT_W-1:0] CNT_STEP_SINGLE = 3'h1;
  localparam logic [CNT_W-1:0] CNT_STEP_DUAL = 3'h2;
  localparam int unsigned SYNC_STAGES = 3;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // Byte handed from the core to the link
  typedef struct packed {
    logic [7:0] data;
    logic drive;
    logic dual;
  } tx_req_t;

  // Pin drive of the two data lines
  typedef struct packed {
    logic lo_out;
    logic lo_oe_n;
    logic hi_out;
    logic hi_oe_n;
  } pin_drive_t;

  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_ACTIVE,
    ST_BUSY_WAIT
  } dev_state_t;
endpackage : flash_spi_pkg

// ==== design/pin_sync.sv ====
// Three-stage synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk; the output moves only when stages two and three agree.
`timescale 1ns/100ps
module pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Signals
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge clk) begin
    s1_q <= async_in;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sync_out <= RST_VAL;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          sync_out[i] <= s3_q[i];
        end
      end
    end
  end
endmodule : pin_sync

// ==== design/flash_spi_front.sv ====
// Serial bus front end of a small serial flash: select, shift in, shift out, dual read, pause.
// Assumes the host makes the serial clock (modes 0 and 3) and the core feeds bytes quasi-statically.
`timescale 1ns/100ps

// Contract
// - With select inactive the device is deselected, goes to standby (not deep power-down) and floats its output.
// - While deselected nothing on the serial input is shifted into any register.
// - A falling select edge starts an operation and a rising select edge ends it.
// - If a program or erase runs when select rises, standby waits until it finishes.
// - Every command, address and data bit is sampled on a rising serial clock edge.
// - Every output bit is launched on a falling serial clock edge.
// - In dual read the input line turns into an output and two bits leave per falling edge.
// - In dual read the output line keeps driving the first bit of each pair on every falling edge.
// - Both idle-low and idle-high serial clock modes work.
// - While pause is low, clock edges and input data are ignored and the output floats.
// - Pause starts only with select active and clock low, and leaves internal operations alone; the code pauses as soon as hold_n is low, whatever the clock level.
module flash_spi_front (
  // Core clock and reset
  input wire logic clk,
  input wire logic srst,
  // Link pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic dual_line_lo_in,
  output logic dual_line_lo_out,
  output logic dual_line_lo_oe_n,
  output logic dual_line_hi_out,
  output logic dual_line_hi_oe_n,
  // Core side: received bytes and frame events
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic frame_start,
  output logic frame_end,
  // Core side: byte to send and operation status
  input wire flash_spi_pkg::tx_req_t tx_req,
  input wire logic busy,
  output logic standby
);
  import flash_spi_pkg::*;

  // ****************************************
  // Link domain (serial clock)
  // ****************************************
  // Reset of the toggle flop, registered so the link sees a clean level
  logic link_rst_q;
  always_ff @(posedge clk) begin
    link_rst_q <= srst;
  end

  logic [CNT_W-1:0] rx_cnt_q;
  logic [7:0] rx_shift_q;
  logic [7:0] rx_byte_q;
  logic started_q;

  // Select high clears the shifter asynchronously, so no stale bits survive a frame
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      rx_cnt_q <= CNT_ZERO;
      rx_shift_q <= BYTE_RST;
      started_q <= 1'b0;
    end else if (hold_n) begin
      rx_shift_q <= {rx_shift_q[6:0], dual_line_lo_in};
      rx_cnt_q <= rx_cnt_q + CNT_STEP_SINGLE;
      // Output waits for one whole byte in, so the first byte is always taken as command
      if (rx_cnt_q == CNT_LAST) begin
        started_q <= 1'b1;
      end
    end
  end

  // Not cleared by select, so the core can still fetch the last byte after the frame ends
  always_ff @(posedge sck) begin
    if (!cs_n && hold_n && rx_cnt_q == CNT_LAST) begin
      rx_byte_q <= {rx_shift_q[6:0], dual_line_lo_in};
    end
  end

  // Toggle kept apart so a frame end does not fake a byte event
  logic rx_tog_q;
  always_ff @(posedge sck or posedge link_rst_q) begin
    if (link_rst_q) begin
      rx_tog_q <= 1'b0;
    end else if (!cs_n && hold_n && rx_cnt_q == CNT_LAST) begin
      rx_tog_q <= ~rx_tog_q;
    end
  end

  logic [CNT_W-1:0] tx_cnt_q;
  logic [7:0] tx_shift_q;
  logic tx_drive_q;
  logic tx_dual_q;
  logic lo_bit_q;
  logic hi_bit_q;

  // Mode 3 gives a falling edge before the first rising one; started_q skips it
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      tx_cnt_q <= CNT_ZERO;
      tx_shift_q <= BYTE_RST;
      tx_drive_q <= 1'b0;
      tx_dual_q <= 1'b0;
      lo_bit_q <= 1'b0;
      hi_bit_q <= 1'b0;
    end else if (hold_n && started_q) begin
      if (tx_cnt_q == CNT_ZERO) begin
        // Core must hold tx_req stable from the previous byte event to here
        tx_drive_q <= tx_req.drive;
        tx_dual_q <= tx_req.dual;
        if (tx_req.dual) begin
          hi_bit_q <= tx_req.data[7];
          lo_bit_q <= tx_req.data[6];
          tx_shift_q <= {tx_req.data[5:0], 2'b00};
          tx_cnt_q <= CNT_STEP_DUAL;
        end else begin
          hi_bit_q <= tx_req.data[7];
          tx_shift_q <= {tx_req.data[6:0], 1'b0};
          tx_cnt_q <= CNT_STEP_SINGLE;
        end
      end else if (tx_dual_q) begin
        hi_bit_q <= tx_shift_q[7];
        lo_bit_q <= tx_shift_q[6];
        tx_shift_q <= {tx_shift_q[5:0], 2'b00};
        tx_cnt_q <= tx_cnt_q + CNT_STEP_DUAL;
      end else begin
        hi_bit_q <= tx_shift_q[7];
        tx_shift_q <= {tx_shift_q[6:0], 1'b0};
        tx_cnt_q <= tx_cnt_q + CNT_STEP_SINGLE;
      end
    end
  end

  // ****************************************
  // Core domain crossings
  // ****************************************
  logic cs_n_s;
  logic hold_n_s;
  logic drive_s;
  logic dual_s;
  logic tog_s;
  pin_sync #(.WIDTH(5), .RST_VAL(5'h18)) u_sync (
    .clk(clk),
    .srst(srst),
    .async_in({cs_n, hold_n, tx_drive_q, tx_dual_q, rx_tog_q}),
    .sync_out({cs_n_s, hold_n_s, drive_s, dual_s, tog_s})
  );

  // ****************************************
  // Pin drive
  // ****************************************
  // Data bits leave straight from falling-edge flops; enables trail by the sync delay
  always_ff @(posedge clk) begin
    if (srst) begin
      dual_line_hi_oe_n <= 1'b1;
      dual_line_lo_oe_n <= 1'b1;
    end else begin
      dual_line_hi_oe_n <= ~(!cs_n_s && hold_n_s && drive_s);
      dual_line_lo_oe_n <= ~(!cs_n_s && hold_n_s && drive_s && dual_s);
    end
  end

  assign dual_line_hi_out = hi_bit_q;
  assign dual_line_lo_out = lo_bit_q;

  // ****************************************
  // Core side events and standby
  // ****************************************
  logic tog_seen_q;
  logic cs_n_d1_q;
  dev_state_t state_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      tog_seen_q <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= BYTE_RST;
    end else begin
      tog_seen_q <= tog_s;
      rx_valid <= (tog_s != tog_seen_q);
      // Byte register is stable for a whole byte time after the toggle lands
      if (tog_s != tog_seen_q) begin
        rx_data <= rx_byte_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cs_n_d1_q <= 1'b1;
      frame_start <= 1'b0;
      frame_end <= 1'b0;
    end else begin
      cs_n_d1_q <= cs_n_s;
      frame_start <= cs_n_d1_q && !cs_n_s;
      frame_end <= !cs_n_d1_q && cs_n_s;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_STANDBY;
      standby <= 1'b1;
    end else begin
      case (state_q)
        ST_STANDBY: begin
          if (!cs_n_s) begin
            state_q <= ST_ACTIVE;
            standby <= 1'b0;
          end
        end
        ST_ACTIVE: begin
          if (cs_n_s && busy) begin
            state_q <= ST_BUSY_WAIT;
          end else if (cs_n_s) begin
            state_q <= ST_STANDBY;
            standby <= 1'b1;
          end
        end
        ST_BUSY_WAIT: begin
          // Pause never reaches here, so internal work runs on
          if (!cs_n_s) begin
            state_q <= ST_ACTIVE;
          end else if (!busy) begin
            state_q <= ST_STANDBY;
            standby <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_STANDBY;
          standby <= 1'b1;
        end
      endcase
    end
  end
endmodule : flash_spi_front

// ==== testbench/flash_spi_front_chk.sv ====
// Assertions on the flash front end ports.
// Assumes it is bound to flash_spi_front.
`timescale 1ns/100ps
module flash_spi_front_chk (
  // Watched ports
  input wire logic clk,
  input wire logic srst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic dual_line_lo_out,
  input wire logic dual_line_lo_oe_n,
  input wire logic dual_line_hi_out,
  input wire logic dual_line_hi_oe_n,
  input wire logic rx_valid,
  input wire logic busy,
  input wire logic standby
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  reset_idle_a: assert property (disable iff (1'b0) srst |=> standby && !rx_valid && dual_line_hi_oe_n)
    else $error("reset");
  desel_float_a: assert property (cs_n [*8] |-> dual_line_hi_oe_n && dual_line_lo_oe_n)
    else $error("deselect");
  pause_float_a: assert property (!hold_n [*8] |-> dual_line_hi_oe_n && dual_line_lo_oe_n)
    else $error("pause");
  dual_pair_a: assert property (!dual_line_lo_oe_n [*3] |-> !dual_line_hi_oe_n)
    else $error("pair");
  launch_edge_a: assert property (($changed(dual_line_hi_out) || $changed(dual_line_lo_out)) && !cs_n |-> !sck)
    else $error("launch");
  busy_hold_a: assert property (busy && !standby |=> !standby)
    else $error("busy");
  standby_rise_a: assert property ($rose(standby) |-> !$past(busy))
    else $error("standby");
  valid_pulse_a: assert property (rx_valid |=> !rx_valid)
    else $error("valid");
  byte_c: cover property (rx_valid);
  dual_c: cover property (!dual_line_lo_oe_n);
  wait_c: cover property ($fell(busy) ##1 $rose(standby));
endmodule : flash_spi_front_chk

bind flash_spi_front flash_spi_front_chk chk (.clk(clk), .srst(srst), .sck(sck), .cs_n(cs_n), .hold_n(hold_n),
  .dual_line_lo_out(dual_line_lo_out), .dual_line_lo_oe_n(dual_line_lo_oe_n), .dual_line_hi_out(dual_line_hi_out),
  .dual_line_hi_oe_n(dual_line_hi_oe_n), .rx_valid(rx_valid), .busy(busy), .standby(standby));

// ==== testbench/spi_host.sv ====
// Host model: select, link clock (30 ns), pause, serial input.
// Assumes one caller at a time.
`timescale 1ns/100ps
module spi_host (
  // Link pins
  output logic sck,
  output logic cs_n,
  output logic hold_n,
  output logic si,
  input wire logic hi,
  input wire logic lo
);
  logic cpol;
  // Brief select pulse at start clears the link shifters, which have no other reset
  initial begin
    {cs_n, hold_n, sck, si, cpol} = 5'h08;
    #1 cs_n = 1'b1;
  end
  task automatic open();
    sck = cpol;
    #15 cs_n = 1'b0;
    #15;
  endtask : open
  task automatic close();
    sck = cpol;
    #15 cs_n = 1'b1;
    si = ~si;
    #30;
  endtask : close
  // Clock stands still outside frames except here, on purpose, and when open moves it to a changed cpol
  task automatic noise();
    repeat (8) #15 {sck, si} = {~sck, ~si};
  endtask : noise
  task automatic xfer(input logic [7:0] tx, input int n, input int pz, output logic [7:0] hb, output logic [7:0] lb);
    for (int i = 0; i < n; i++) begin
      sck = 1'b0;
      si = tx[7-i];
      // Pause moves a step apart from any clock edge, so the design never sees both at once
      if (i == pz) begin
        #15 hold_n = 1'b0;
        repeat (4) #15 {sck, si} = {~sck, ~si};
        #15 hold_n = 1'b1;
      end
      #15 sck = 1'b1;
      hb[7-i] = hi;
      lb[7-i] = lo;
      #15;
    end
  endtask : xfer
endmodule : spi_host

// ==== testbench/serial_flash_spi_front_end_test.sv ====
// Bench: host model, queue model of received bytes, core side.
// Assumes the checker binds itself to the design.
`timescale 1ns/100ps
module serial_flash_spi_front_end_test;
  import flash_spi_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic busy = 1'b0;
  tx_req_t tx_req = '0;
  logic sck, cs_n, hold_n, si, lo_in, lo_out, lo_oe_n, hi_out, hi_oe_n, rx_valid, standby;
  logic [7:0] rx_data;
  logic [7:0] exp_q[$];
  int bad_count = 0;
  int comparisons = 0;
  always #2 clk = ~clk;
  assign lo_in = lo_oe_n ? si : lo_out;
  spi_host host (.sck(sck), .cs_n(cs_n), .hold_n(hold_n), .si(si), .hi(hi_out), .lo(lo_in));
  flash_spi_front uut (.clk(clk), .srst(srst), .sck(sck), .cs_n(cs_n), .hold_n(hold_n), .dual_line_lo_in(lo_in),
    .dual_line_lo_out(lo_out), .dual_line_lo_oe_n(lo_oe_n), .dual_line_hi_out(hi_out), .dual_line_hi_oe_n(hi_oe_n),
    .rx_data(rx_data), .rx_valid(rx_valid), .frame_start(), .frame_end(), .tx_req(tx_req), .busy(busy),
    .standby(standby));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic summarize();
    $display("bad_count %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  // ***
  // Model: each byte seen must be the oldest one sent
  // ***
  always @(posedge clk) begin
    if (rx_valid === 1'b1) chk("rx_data", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, rx_data);
  end
  initial begin
    logic [7:0] h, l, c, d, b;
    logic [3:0] e, f;
    void'($urandom(46423));
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (6) @(posedge clk);
    for (int m = 0; m < 4; m++) begin
      d = 8'($urandom);
      e = {d[7], d[5], d[3], d[1]};
      f = {d[6], d[4], d[2], d[0]};
      c = m[1] ? 8'h00 : 8'($urandom);
      b = m[1] ? {f, f} : 8'($urandom);
      @(posedge clk) tx_req <= '{data: d, drive: 1'b1, dual: m[1]};
      host.cpol = m[0];
      exp_q.push_back(c);
      exp_q.push_back(b);
      host.open();
      host.xfer(c, 8, 9, h, l);
      host.xfer(b, 8, m == 3 ? 4 : 9, h, l);
      host.close();
      chk("hi_line", m[1] ? {e, e} : d, h);
      if (m[1]) chk("lo_line", b, l);
      $display("test dual %0d mode %0d done", m[1], m[0] * 3);
    end
    @(posedge clk) tx_req <= '0;
    c = 8'($urandom);
    exp_q.push_back(c);
    host.open();
    host.xfer(~c, 5, 9, h, l);
    host.close();
    host.noise();
    host.open();
    host.xfer(c, 8, 3, h, l);
    host.close();
    $display("test partial pause done");
    host.open();
    @(posedge clk) busy <= 1'b1;
    host.close();
    repeat (20) @(posedge clk);
    chk("standby_busy", 8'h00, {7'h0, standby});
    busy <= 1'b0;
    for (int k = 0; k < 4 && standby !== 1'b1; k++) @(posedge clk);
    chk("standby_idle", 8'h01, {7'h0, standby});
    for (int k = 0; k < 50 && exp_q.size() > 0; k++) @(posedge clk);
    chk("rx_left", 8'h00, 8'(exp_q.size()));
    $display("test busy done");
    summarize();
  end
endmodule : serial_flash_spi_front_end_test
